// File: logic/sqi_pkg.sv
// Purpose: shared constants and types for the serial queue interrupt block
// Assumes: 32-bit Avalon-MM data, registers in the low 16 bits
// Notes: register offsets are byte addresses on one aligned word each
package sqi_pkg;
   localparam int ADDR_W = 5;
   localparam int PTR_W = 4;
   localparam int RAM_ADDR_W = 6;

   localparam logic [ADDR_W-1:0] OFF_DELAY = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_WRAP = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_RAM_ADDR = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_DATA = 5'h10;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Command section of the RAM space is 0x20 to 0x2F
   localparam logic [1:0] CMD_SECTION = 2'h2;
   localparam int RUN_BIT = 15;

   localparam logic [15:0] IRQ_WR_MASK = 16'hDD00;
   localparam logic [15:0] IRQ_FLAG_MASK = 16'h000D;
   localparam logic [15:0] IRQ_READ_MASK = 16'hDD0D;
   localparam logic [15:0] WRAP_WR_MASK = 16'hFF0F;
   localparam logic [15:0] IRQ_RESET = 16'h0000;
   localparam logic [15:0] WRAP_RESET = 16'h0000;
   localparam logic [RAM_ADDR_W-1:0] RAM_ADDR_RESET = 6'h00;
   localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;

   typedef struct packed {
      logic collision_bus_error_en;
      logic abort_bus_error_en;
      logic rsv13;
      logic abort_lockout;
      logic collision_irq_en;
      logic abort_irq_en;
      logic rsv9;
      logic finished_irq_en;
      logic [3:0] rsv7_4;
      logic collision_flag;
      logic abort_flag;
      logic rsv1;
      logic finished_flag;
   } sqi_irq_type;

   typedef struct packed {
      logic halt;
      logic wraparound_enable;
      logic wrap_to_start;
      logic cs_idle_level;
      logic [PTR_W-1:0] end_queue_pointer;
      logic [PTR_W-1:0] completed_pointer;
      logic [PTR_W-1:0] start_queue_pointer;
   } sqi_wrap_type;

   typedef struct packed {
      logic finished;
      logic stop;
      logic [PTR_W-1:0] cur_entry;
      logic [PTR_W-1:0] completed;
   } sqi_seq_evt_type;
endpackage

// File: logic/sqi_queue_seq.sv
// Purpose: command queue pointer walk, halt and wraparound handling
// Assumes: cmd_done is a one-cycle pulse from the transfer engine
// Notes: finished and stop are combinational one-cycle pulses
`timescale 1ns/1ns
module sqi_queue_seq (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic sw_abort,
   input wire logic cmd_done,
   input wire sqi_pkg::sqi_wrap_type ctrl,
   output sqi_pkg::sqi_seq_evt_type evt
);
   import sqi_pkg::*;

   typedef enum logic {SEQ_IDLE, SEQ_RUN} sqi_seq_state_type;
   sqi_seq_state_type state_reg, state_next;
   logic [PTR_W-1:0] cur_reg, cur_next, done_reg, done_next;
   logic at_end, finished, stop;

   assign at_end = cur_reg == ctrl.end_queue_pointer;

   always_comb begin
      state_next = state_reg;
      cur_next = cur_reg;
      done_next = done_reg;
      finished = 1'b0;
      stop = 1'b0;
      case (state_reg)
         SEQ_IDLE: begin
            if (start) begin
               state_next = SEQ_RUN;
               cur_next = ctrl.start_queue_pointer;
            end
         end
         SEQ_RUN: begin
            if (sw_abort) begin
               state_next = SEQ_IDLE;
            end else if (cmd_done) begin
               done_next = cur_reg;
               if (ctrl.halt) begin
                  finished = 1'b1;
                  stop = 1'b1;
                  state_next = SEQ_IDLE;
               end else if (at_end) begin
                  finished = 1'b1;
                  if (ctrl.wraparound_enable) begin
                     cur_next = ctrl.wrap_to_start ? ctrl.start_queue_pointer : PTR_RESET;
                  end else begin
                     stop = 1'b1;
                     state_next = SEQ_IDLE;
                  end
               end else begin
                  cur_next = cur_reg + 4'h1;
               end
            end
         end
         default: state_next = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= SEQ_IDLE;
         cur_reg <= PTR_RESET;
         done_reg <= PTR_RESET;
      end else begin
         state_reg <= state_next;
         cur_reg <= cur_next;
         done_reg <= done_next;
      end
   end

   assign evt = '{finished: finished, stop: stop, cur_entry: cur_reg, completed: done_reg};

   ////////////////////////////////////////////////////////////////////////////
   sequence s_end_done;
      state_reg == SEQ_RUN && cmd_done && !sw_abort && !ctrl.halt && at_end;
   endsequence

   halt_stops_a: assert property (@(posedge clk) disable iff (!reset_n)
      state_reg == SEQ_RUN && cmd_done && !sw_abort && ctrl.halt
      |-> finished && stop ##1 state_reg == SEQ_IDLE)
      else $error("halt did not stop the queue");

   end_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_end_done and !ctrl.wraparound_enable |-> stop ##1 state_reg == SEQ_IDLE)
      else $error("queue did not stop at the end pointer");

   wrap_again_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_end_done and ctrl.wraparound_enable && !ctrl.wrap_to_start
      |-> finished && !stop ##1 state_reg == SEQ_RUN && cur_reg == PTR_RESET)
      else $error("wraparound did not restart at entry zero");

   start_ptr_a: assert property (@(posedge clk) disable iff (!reset_n)
      state_reg == SEQ_IDLE && start
      |=> state_reg == SEQ_RUN && cur_reg == $past(ctrl.start_queue_pointer))
      else $error("queue did not start at the start pointer");

   wrap_start_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_end_done and ctrl.wraparound_enable && ctrl.wrap_to_start
      |=> state_reg == SEQ_RUN && cur_reg == $past(ctrl.start_queue_pointer))
      else $error("wraparound did not restart at the start pointer");
endmodule

// File: logic/sqi_irq_status.sv
// Purpose: interrupt enables, status flags and queue run control over Avalon-MM
// Assumes: master holds each request until waitrequest is seen low
// Notes: every access answers on the second cycle of the request
//
// What this block does
// - Collision bus-error enable set: write to executing command entry gets error.
// - Abort bus-error enable set: clearing run enable while running gets error.
// - Lock-out set: software writes cannot clear run enable; only completion does.
// - Collision interrupt enable gates the collision flag request.
// - Abort interrupt enable gates the abort flag request.
// - Finished interrupt enable gates the finished flag request.
// - Set collision flag on a write to the executing command entry.
// - Set abort flag when software clears run enable instead of completion.
// - Set finished flag on end-pointer command completion or after halt.
// - In wraparound, set finished flag on every end-pointer completion.
// - Flags clear on writing one or on any read of the register; writing zero leaves them.
// - Setting run enable starts the queue; controller clears it on completion.
// - Halt request finishes the current command then stops.
// - End pointer names the last command and the finished-flag trigger.
// - Wraparound off stops after end command; on restarts at zero or start pointer.
`timescale 1ns/1ns
module sqi_irq_status (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [sqi_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic [1:0] response,
   output logic waitrequest,
   output logic irq,
   input wire logic cmd_done,
   output logic [sqi_pkg::PTR_W-1:0] cmd_entry,
   output logic queue_active
);
   import sqi_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake: first cycle waits, second cycle completes
   logic req, first, done, ack_reg, ack_next;
   logic [15:0] wd, be_mask;

   assign req = read | write;
   assign first = req & ~ack_reg;
   assign done = req & ack_reg;
   assign waitrequest = first;
   assign wd = writedata[15:0];
   assign be_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

   always_comb begin
      ack_next = first;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers
   sqi_irq_type irq_ctrl_status_reg, irq_ctrl_status_next;
   sqi_wrap_type wrap_ctrl_reg, wrap_ctrl_next;
   logic run_reg, run_next;
   logic [RAM_ADDR_W-1:0] ram_addr_reg, ram_addr_next;
   logic coll_hit_reg, coll_hit_next, clr_hit_reg, clr_hit_next;
   logic [31:0] readdata_next;
   logic [1:0] response_next;
   sqi_seq_evt_type evt;

   ////////////////////////////////////////////////////////////////////////////
   // Access decode, judged on the first cycle of a request
   logic hit_delay, hit_wrap, hit_irq, hit_raddr, hit_data;
   logic coll_now, clr_now, coll_err, abort_err;

   assign hit_delay = address == OFF_DELAY;
   assign hit_wrap = address == OFF_WRAP;
   assign hit_irq = address == OFF_IRQ;
   assign hit_raddr = address == OFF_RAM_ADDR;
   assign hit_data = address == OFF_DATA;

   assign coll_now = write & hit_data & run_reg & (ram_addr_reg[5:4] == CMD_SECTION)
      & (ram_addr_reg[PTR_W-1:0] == evt.cur_entry);
   assign clr_now = write & hit_delay & byteenable[1] & ~wd[RUN_BIT] & run_reg;
   assign coll_err = coll_now & irq_ctrl_status_reg.collision_bus_error_en;
   assign abort_err = clr_now & irq_ctrl_status_reg.abort_bus_error_en;

   always_comb begin
      coll_hit_next = coll_hit_reg;
      clr_hit_next = clr_hit_reg;
      readdata_next = readdata;
      response_next = response;
      if (first) begin
         coll_hit_next = coll_now;
         clr_hit_next = clr_now & ~abort_err & ~irq_ctrl_status_reg.abort_lockout;
         response_next = (coll_err | abort_err) ? RESP_SLVERR : RESP_OKAY;
         readdata_next = 32'h0000_0000;
         if (read) begin
            if (hit_delay) begin
               readdata_next[RUN_BIT] = run_reg;
            end else if (hit_wrap) begin
               readdata_next[15:0] = wrap_ctrl_reg;
            end else if (hit_irq) begin
               readdata_next[15:0] = irq_ctrl_status_reg & IRQ_READ_MASK;
            end else if (hit_raddr) begin
               readdata_next[RAM_ADDR_W-1:0] = ram_addr_reg;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Run enable, sequencer and RAM address
   logic start, sw_clear, wr_delay;

   assign wr_delay = done & write & hit_delay & byteenable[1];
   assign start = wr_delay & ~run_reg & wd[RUN_BIT];
   assign sw_clear = done & clr_hit_reg;

   always_comb begin
      run_next = run_reg;
      if (start) begin
         run_next = 1'b1;
      end else if (sw_clear | evt.stop) begin
         run_next = 1'b0;
      end
      ram_addr_next = ram_addr_reg;
      if (done & write & hit_raddr & byteenable[0]) begin
         ram_addr_next = wd[RAM_ADDR_W-1:0];
      end else if (done & hit_data) begin
         ram_addr_next = ram_addr_reg + 6'h01;
      end
   end

   sqi_queue_seq u_seq (
      .clk(clk),
      .reset_n(reset_n),
      .start(start),
      .sw_abort(sw_clear),
      .cmd_done(cmd_done),
      .ctrl(wrap_ctrl_reg),
      .evt(evt)
   );

   always_comb begin
      wrap_ctrl_next = wrap_ctrl_reg;
      if (done & write & hit_wrap) begin
         wrap_ctrl_next = (wrap_ctrl_reg & ~(WRAP_WR_MASK & be_mask))
            | (wd & WRAP_WR_MASK & be_mask);
      end
      wrap_ctrl_next.completed_pointer = evt.completed;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enables and sticky flags; a set wins over a clear in the same cycle
   logic [15:0] flag_clr, flag_set;
   logic irq_next;

   always_comb begin
      flag_clr = 16'h0000;
      if (done & hit_irq & read) begin
         flag_clr = IRQ_FLAG_MASK;
      end else if (done & hit_irq & write) begin
         flag_clr = wd & be_mask & IRQ_FLAG_MASK;
      end
      flag_set = 16'h0000;
      flag_set[3] = done & coll_hit_reg;
      flag_set[2] = sw_clear;
      flag_set[0] = evt.finished;
      irq_ctrl_status_next = irq_ctrl_status_reg;
      if (done & hit_irq & write) begin
         irq_ctrl_status_next = (irq_ctrl_status_reg & ~(IRQ_WR_MASK & be_mask))
            | (wd & IRQ_WR_MASK & be_mask);
      end
      irq_ctrl_status_next = (irq_ctrl_status_next & ~flag_clr) | flag_set;
      irq_next = (irq_ctrl_status_next.collision_flag
         & irq_ctrl_status_next.collision_irq_en)
         | (irq_ctrl_status_next.abort_flag
         & irq_ctrl_status_next.abort_irq_en)
         | (irq_ctrl_status_next.finished_flag
         & irq_ctrl_status_next.finished_irq_en);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_reg <= 1'b0;
         irq_ctrl_status_reg <= IRQ_RESET;
         wrap_ctrl_reg <= WRAP_RESET;
         run_reg <= 1'b0;
         ram_addr_reg <= RAM_ADDR_RESET;
         coll_hit_reg <= 1'b0;
         clr_hit_reg <= 1'b0;
         readdata <= 32'h0000_0000;
         response <= RESP_OKAY;
         irq <= 1'b0;
         cmd_entry <= PTR_RESET;
      end else begin
         ack_reg <= ack_next;
         irq_ctrl_status_reg <= irq_ctrl_status_next;
         wrap_ctrl_reg <= wrap_ctrl_next;
         run_reg <= run_next;
         ram_addr_reg <= ram_addr_next;
         coll_hit_reg <= coll_hit_next;
         clr_hit_reg <= clr_hit_next;
         readdata <= readdata_next;
         response <= response_next;
         irq <= irq_next;
         cmd_entry <= evt.cur_entry;
      end
   end

   assign queue_active = run_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_first;
      req && waitrequest;
   endsequence

   sequence s_answer;
      req && !waitrequest;
   endsequence

   bus_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_first |=> s_answer)
      else $error("request not answered on second cycle");

   coll_error_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_first and coll_now && irq_ctrl_status_reg.collision_bus_error_en
      |=> s_answer and response == RESP_SLVERR ##1 irq_ctrl_status_reg.collision_flag)
      else $error("collision write not answered with error and flag");

   abort_error_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_first and clr_now && irq_ctrl_status_reg.abort_bus_error_en
      |=> response == RESP_SLVERR)
      else $error("abort attempt not answered with error");

   lockout_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_first and clr_now && irq_ctrl_status_reg.abort_lockout && !cmd_done
      |=> !evt.stop |=> run_reg)
      else $error("lock-out let software clear run enable");

   abort_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      sw_clear |=> irq_ctrl_status_reg.abort_flag && !run_reg)
      else $error("software clear did not raise abort flag");

   finish_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      evt.finished |=> irq_ctrl_status_reg.finished_flag)
      else $error("finished flag not set");

   zero_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      irq_ctrl_status_reg.finished_flag && done && write && hit_irq && !wd[0]
      |=> irq_ctrl_status_reg.finished_flag)
      else $error("writing zero changed a flag");

   irq_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      !(irq_ctrl_status_reg.collision_flag && irq_ctrl_status_reg.collision_irq_en)
      && !(irq_ctrl_status_reg.abort_flag && irq_ctrl_status_reg.abort_irq_en)
      && !(irq_ctrl_status_reg.finished_flag && irq_ctrl_status_reg.finished_irq_en)
      |-> !irq)
      else $error("interrupt raised with no enabled flag");

   irq_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      irq_ctrl_status_reg.collision_flag && irq_ctrl_status_reg.collision_irq_en |-> irq)
      else $error("enabled collision flag gave no interrupt");

   reserved_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_first and read && hit_irq |=> (readdata[15:0] & ~IRQ_READ_MASK) == 16'h0000)
      else $error("reserved bits read non-zero");

   coll_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_first and coll_now |=> s_answer ##1 irq_ctrl_status_reg.collision_flag)
      else $error("collision write did not raise the flag");

   abort_block_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_first and clr_now && irq_ctrl_status_reg.abort_bus_error_en |=> !sw_clear)
      else $error("abort error let the clear through");

   lockout_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      s_first and clr_now && irq_ctrl_status_reg.abort_lockout |=> !sw_clear)
      else $error("lock-out let a software clear through");

   start_run_a: assert property (@(posedge clk) disable iff (!reset_n)
      start |=> run_reg)
      else $error("run enable not set by start");

   run_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
      evt.stop |=> !run_reg)
      else $error("run enable not cleared on completion");

   flag_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      done && write && hit_irq && byteenable[0] && wd[0] && !evt.finished
      |=> !irq_ctrl_status_reg.finished_flag)
      else $error("writing one did not clear the finished flag");

   abort_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
      irq_ctrl_status_reg.abort_flag && irq_ctrl_status_reg.abort_irq_en |-> irq)
      else $error("enabled abort flag gave no interrupt");

   finish_irq_a: assert property (@(posedge clk) disable iff (!reset_n)
      irq_ctrl_status_reg.finished_flag && irq_ctrl_status_reg.finished_irq_en |-> irq)
      else $error("enabled finished flag gave no interrupt");

   reserved_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (irq_ctrl_status_reg & ~IRQ_READ_MASK) == 16'h0000)
      else $error("reserved bits held non-zero");
endmodule

// File: verification/sqi_engine_model.sv
// Purpose: transfer engine model that finishes one command entry after a delay
// Assumes: the queue runs while queue_active is high
// Notes: slow stretches each command so software can act mid-queue
`timescale 1ns/1ns
module sqi_engine_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic queue_active,
   input wire logic slow,
   output logic cmd_done,
   output logic [7:0] done_count
);
   logic [9:0] wait_reg;
   logic [9:0] span;
   assign span = slow ? 10'h12C : 10'h004;
   ////////////////////////////////////////////////////////////////////////
   // One-cycle done pulse, only while the queue runs
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_reg <= 10'h000;
         cmd_done <= 1'b0;
         done_count <= 8'h00;
      end else if (!queue_active || cmd_done) begin
         wait_reg <= 10'h000;
         cmd_done <= 1'b0;
      end else if (wait_reg >= span) begin
         wait_reg <= 10'h000;
         cmd_done <= 1'b1;
         done_count <= done_count + 8'h01;
      end else begin
         wait_reg <= wait_reg + 10'h001;
      end
   end
endmodule

// File: verification/sqi_irq_status_tb.sv
// Purpose: self-checking bench for the serial queue interrupt block
// Assumes: one wait state per access, engine model on the command side
// Notes: bus answers are checked by a monitor against a queue of notes
`timescale 1ns/1ns
module sqi_irq_status_tb;
   import sqi_pkg::*;
   typedef struct {logic [1:0] resp; logic [15:0] data; logic rd;} sqi_note_type;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [ADDR_W-1:0] address = '0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] readdata;
   logic [1:0] response;
   logic waitrequest;
   logic irq;
   logic cmd_done;
   logic [PTR_W-1:0] cmd_entry;
   logic queue_active;
   logic slow = 1'b0;
   logic [7:0] done_count;
   logic [7:0] base;
   logic [15:0] v;
   int err_count = 0;
   int num_checks = 0;
   sqi_note_type notes[$];
   sqi_note_type note;
   logic [15:0] ab_cfg[4] = '{16'h0400, 16'h4400, 16'h1400, 16'h0000};
   logic [1:0] ab_resp[4] = '{RESP_OKAY, RESP_SLVERR, RESP_OKAY, RESP_OKAY};
   logic ab_act[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   logic ab_irq[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
   logic [15:0] co_cfg[2] = '{16'h0800, 16'h8000};
   logic [1:0] co_resp[2] = '{RESP_OKAY, RESP_SLVERR};
   logic co_irq[2] = '{1'b1, 1'b0};

   always #5 clk = ~clk;

   sqi_irq_status DUT (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .response(response), .waitrequest(waitrequest), .irq(irq), .cmd_done(cmd_done),
      .cmd_entry(cmd_entry), .queue_active(queue_active));
   sqi_engine_model engine (.clk(clk), .reset_n(reset_n), .queue_active(queue_active),
      .slow(slow), .cmd_done(cmd_done), .done_count(done_count));
   ////////////////////////////////////////////////////////////////////////
   // Bus master and helpers
   task automatic end_of_test();
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [15:0] d,
      input logic [1:0] er, input logic [15:0] ed, input logic [3:0] be);
      int n;
      notes.push_back('{er, ed, !w});
      @(posedge clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= {16'h0000, d};
      byteenable <= be;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) begin
         err_count++;
         $display("Error %0t: bus answer missing", $time);
      end
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d,
      input logic [1:0] er, input logic [3:0] be = 4'h3);
      bus(1'b1, a, d, er, 16'h0000, be);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] ed);
      bus(1'b0, a, 16'h0000, RESP_OKAY, ed, 4'h3);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic wait_for(input logic on_irq);
      int n;
      settle();
      n = 0;
      while ((on_irq ? irq !== 1'b1 : queue_active !== 1'b0) && n < 3000) begin
         @(posedge clk);
         n++;
      end
      #1;
      chk(16'(n < 3000), 16'h0001);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Answer monitor
   always @(posedge clk) begin
      if (reset_n === 1'b1 && (read || write) && waitrequest === 1'b0) begin
         num_checks++;
         if (notes.size() == 0) begin
            err_count++;
            $display("Error %0t: answer with no request", $time);
         end else begin
            note = notes.pop_front();
            if (response !== note.resp || (note.rd && readdata !== {16'h0000, note.data})) begin
               err_count++;
               $display("Error %0t: answer %h/%h expected %h/%h", $time, response,
                  readdata, note.resp, note.data);
            end
         end
      end
   end
   initial begin
      #200000;
      err_count++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   initial begin
      void'($urandom(32'h096E));
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      rd(OFF_IRQ, 16'h0000);
      rd(OFF_WRAP, 16'h0000);
      rd(OFF_DELAY, 16'h0000);
      wr(5'h1C, 16'hFFFF, RESP_OKAY);
      rd(5'h1C, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom()) & IRQ_READ_MASK;
         wr(OFF_IRQ, v, RESP_OKAY);
         rd(OFF_IRQ, v & IRQ_WR_MASK);
      end
      // Plain queue, entries 0 to 2, interrupt masked
      wr(OFF_IRQ, 16'h0000, RESP_OKAY);
      wr(OFF_WRAP, 16'h0200, RESP_OKAY);
      base = done_count;
      wr(OFF_DELAY, 16'h8000, RESP_OKAY);
      wait_for(1'b0);
      chk(16'(done_count - base), 16'h0003);
      chk(16'(irq), 16'h0000);
      rd(OFF_DELAY, 16'h0000);
      wr(OFF_IRQ, 16'h0100, RESP_OKAY);
      settle();
      chk(16'(irq), 16'h0001);
      wr(OFF_IRQ, 16'h0101, RESP_OKAY, 4'h2);
      settle();
      chk(16'(irq), 16'h0001);
      rd(OFF_IRQ, 16'h0101);
      wr(OFF_DELAY, 16'h8000, RESP_OKAY);
      wait_for(1'b0);
      wr(OFF_IRQ, 16'h0101, RESP_OKAY);
      settle();
      chk(16'(irq), 16'h0000);
      rd(OFF_IRQ, 16'h0100);
      // Wraparound to the start pointer over entries 2 and 3, then halt
      wr(OFF_WRAP, 16'h6302, RESP_OKAY);
      wr(OFF_DELAY, 16'h8000, RESP_OKAY);
      wait_for(1'b1);
      wr(OFF_IRQ, 16'h0101, RESP_OKAY);
      wait_for(1'b1);
      chk(16'(queue_active), 16'h0001);
      chk(16'(cmd_entry >> 1), 16'h0001);
      slow <= 1'b1;
      wr(OFF_IRQ, 16'h0101, RESP_OKAY);
      wr(OFF_WRAP, 16'hE302, RESP_OKAY);
      wait_for(1'b0);
      rd(OFF_IRQ, 16'h0101);
      // Software clear of run enable under the abort controls
      wr(OFF_WRAP, 16'h0200, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_IRQ, ab_cfg[i] | 16'h000D, RESP_OKAY);
         wr(OFF_DELAY, 16'h8000, RESP_OKAY);
         wr(OFF_DELAY, 16'h0000, ab_resp[i]);
         settle();
         chk(16'(queue_active), 16'(ab_act[i]));
         chk(16'(irq), 16'(ab_irq[i]));
         rd(OFF_IRQ, ab_cfg[i] | (ab_act[i] ? 16'h0000 : 16'h0004));
         wait_for(1'b0);
      end
      // Writes through the data window while entry 3 runs
      wr(OFF_WRAP, 16'h0503, RESP_OKAY);
      for (int i = 0; i < 2; i++) begin
         wr(OFF_IRQ, co_cfg[i] | 16'h000D, RESP_OKAY);
         wr(OFF_DELAY, 16'h8000, RESP_OKAY);
         settle();
         chk(16'(cmd_entry), 16'h0003);
         wr(OFF_RAM_ADDR, 16'h0024, RESP_OKAY);
         wr(OFF_DATA, 16'hA500, RESP_OKAY);
         wr(OFF_RAM_ADDR, 16'h0023, RESP_OKAY);
         wr(OFF_DATA, 16'h5A00, co_resp[i]);
         settle();
         chk(16'(irq), 16'(co_irq[i]));
         rd(OFF_IRQ, co_cfg[i] | 16'h0008);
         wait_for(1'b0);
      end
      end_of_test();
   end
endmodule
